// *** design/kbe_pkg.sv ***
// Package: constants and carrier types for the keyboard encoder with key-down timer
package kbe_pkg;
  // ==========================================================
  // Matrix and code widths
  localparam int unsigned LINES = 8;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned KEY_COUNT = 58;
  // ==========================================================
  // Host addressing: I/O address 6, registers 1 and 3
  localparam logic [2:0] IO_ADDR = 3'h6;
  localparam logic [1:0] REG_LOCK = 2'h1;
  localparam logic [1:0] REG_CODE = 2'h3;
  localparam int unsigned LOCK_BIT = 7;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned QUAL_MS = 20;
  localparam int unsigned QUAL_CYC = (CLK_HZ / 1000) * QUAL_MS;
  localparam int unsigned CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h0_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h0_0000;
  localparam logic [7:0] LINES_IDLE = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_IDLE = 3'h7;
  // ==========================================================
  // Host strobe group
  typedef struct packed {
    logic wr;
    logic rd;
    logic ack;
    logic [2:0] addr;
    logic [1:0] regsel;
  } kbe_host_s;
  typedef enum {ST_IDLE, ST_TIMING, ST_REQ} kbe_state_e;
endpackage : kbe_pkg

// *** design/kbe_keyboard_encoder.sv ***
// Keyboard encoder with lockout, 20 ms key-down qualifier and service request
// Summary of operation
// - Two priority encoders make row, column codes
// - Encoder outputs are active-low binary
// - Inverting buffer gives host active-high codes
// - Lowest-numbered active line wins
// - 58 keys, each grounds row and column
// - Host writes bit 7 to latch lockout
// - Lockout disables first encoder, cascades second
// - Enabled press asserts key-pressed, starts timer
// - Non-retriggerable 20 ms timer on press
// - Sample at end, valid or discard
// - Valid key-down raises key-down request
// - Key-down and knob requests form low request
// - Acknowledge clears request and re-arms
`timescale 1ns/1ps
module kbe_keyboard_encoder #(
  // Qualifying interval in clock cycles; must fit the CNT_W-bit counter
  parameter int unsigned QUAL_CYCLES = kbe_pkg::QUAL_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Key matrix, pulled low by a pressed key
  input wire logic [7:0] ROW_N,
  input wire logic [7:0] COL_N,
  // Host bus
  input wire kbe_pkg::kbe_host_s HOST,
  input wire logic [7:0] HOST_DATA,
  input wire logic KNOB_REQUEST,
  // Outputs to host
  output logic [7:0] READ_DATA,
  output logic READ_VALID,
  output logic KEY_PRESSED_N,
  output logic KEY_DOWN_REQUEST,
  output logic SERVICE_REQUEST_N,
  output logic LOCKOUT
);
  import kbe_pkg::*;

  // ==========================================================
  // Synchronisers
  logic [7:0] row_s1_q, row_s2_q, row_s3_q, col_s1_q, col_s2_q, col_s3_q;
  logic [7:0] row_d, col_d;
  // Last agreed matrix value, the only copy the encoders see
  logic [7:0] row_d_q, col_d_q;
  // three-stage sampling
  // Hold the last agreed value when stages two and three differ
  always_comb begin
    row_d = (row_s2_q == row_s3_q) ? row_s3_q : row_d_q;
    col_d = (col_s2_q == col_s3_q) ? col_s3_q : col_d_q;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      row_s1_q <= LINES_IDLE;
      row_s2_q <= LINES_IDLE;
      row_s3_q <= LINES_IDLE;
      col_s1_q <= LINES_IDLE;
      col_s2_q <= LINES_IDLE;
      col_s3_q <= LINES_IDLE;
      row_d_q <= LINES_IDLE;
      col_d_q <= LINES_IDLE;
    end else begin
      row_s1_q <= ROW_N;
      row_s2_q <= row_s1_q;
      row_s3_q <= row_s2_q;
      col_s1_q <= COL_N;
      col_s2_q <= col_s1_q;
      col_s3_q <= col_s2_q;
      row_d_q <= row_d;
      col_d_q <= col_d;
    end
  end

  // ==========================================================
  // Priority encoders
  // encode one 8-line group to an active-low code
  // lowest active line has priority; output is ~n
  function automatic logic [3:0] enc(input logic [7:0] lines_n, input logic en_n);
    logic [3:0] r;
    r = {1'b1, CODE_IDLE};
    if (!en_n) begin
      for (int i = LINES - 1; i >= 0; i--) begin
        if (!lines_n[i]) r = {1'b0, ~3'(i)};
      end
    end
    return r; // bit 3 low means a line was active
  endfunction : enc

  logic lock_q, lock_d;
  logic [3:0] row_enc, col_enc;
  logic row_cascade_n;
  // each key grounds one row and one column
  // lockout disables the row encoder, its cascade disables the column one
  always_comb begin
    row_enc = enc(row_d_q, lock_q);
    row_cascade_n = lock_q;
    col_enc = enc(col_d_q, row_cascade_n);
  end
  logic pressed;
  // key-pressed needs both encoders enabled and a line active
  assign pressed = !row_enc[3] && !col_enc[3] && !lock_q;

  // ==========================================================
  // Host strobes
  logic hit_lock, hit_code;
  assign hit_lock = HOST.wr && HOST.addr == IO_ADDR && HOST.regsel == REG_LOCK;
  // code is read at address 6, register 3
  assign hit_code = HOST.rd && HOST.addr == IO_ADDR && HOST.regsel == REG_CODE;
  // latch data bit seven as lockout
  always_comb begin
    lock_d = hit_lock ? HOST_DATA[LOCK_BIT] : lock_q;
  end

  // ==========================================================
  // Key-down timer
  kbe_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic req_q, req_d;
  // non-retriggerable count; sample at end; ack re-arms
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    req_d = req_q;
    unique case (st_q)
      ST_IDLE: begin
        if (pressed) begin
          st_d = ST_TIMING;
          // Load once; later matrix activity never reloads it
          cnt_d = CNT_W'(QUAL_CYCLES);
        end
      end
      ST_TIMING: begin
        if (lock_q) begin
          st_d = ST_IDLE;
        end else if (cnt_q == CNT_ONE) begin
          cnt_d = CNT_ZERO;
          // still held gives valid key-down, else discard
          if (pressed) begin
            st_d = ST_REQ;
            req_d = 1'b1;
          end else begin
            st_d = ST_IDLE;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_REQ: begin
        if (HOST.ack) begin
          req_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Output staging
  logic [7:0] rdata_d;
  // inverting buffer, bit 6 flags key-down request active low
  always_comb begin
    rdata_d = {1'b0, ~req_q, ~row_enc[2:0], ~col_enc[2:0]};
  end

  // Register all state and outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      req_q <= 1'b0;
      READ_DATA <= 8'h00;
      READ_VALID <= 1'b0;
      KEY_PRESSED_N <= 1'b1;
      KEY_DOWN_REQUEST <= 1'b0;
      SERVICE_REQUEST_N <= 1'b1;
      LOCKOUT <= 1'b0;
    end else begin
      lock_q <= lock_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      READ_DATA <= hit_code ? rdata_d : 8'h00;
      READ_VALID <= hit_code;
      KEY_PRESSED_N <= !pressed;
      KEY_DOWN_REQUEST <= req_d;
      // combine key-down and knob requests, active low
      SERVICE_REQUEST_N <= !(req_d || KNOB_REQUEST);
      LOCKOUT <= lock_d;
    end
  end

  // ==========================================================
  // Assertions
  localparam int unsigned KEYS_CHECK = KEY_COUNT;
  a_req_needs_timer: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(req_q) |-> $past(st_q) == ST_TIMING && $past(cnt_q) == CNT_ONE)
    else $error("request rose without a finished interval");
  a_lock_blocks: assert property (@(posedge CLK) disable iff (!RESET_N)
    lock_q |-> !pressed)
    else $error("key encoded while locked out");
  a_lock_latch: assert property (@(posedge CLK) disable iff (!RESET_N)
    hit_lock |=> lock_q == $past(HOST_DATA[LOCK_BIT]))
    else $error("lockout bit not latched");
  a_no_retrigger: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_TIMING && cnt_q != CNT_ONE && !lock_q |=> cnt_q == $past(cnt_q) - CNT_ONE)
    else $error("timer restarted or stalled");
  a_discard: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_TIMING && cnt_q == CNT_ONE && !pressed |=> !req_q && st_q == ST_IDLE)
    else $error("released key not discarded");
  a_ack_clears: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_REQ && HOST.ack |=> !req_q ##1 !KEY_DOWN_REQUEST)
    else $error("acknowledge did not clear request");
  a_srq_combined: assert property (@(posedge CLK) disable iff (!RESET_N)
    SERVICE_REQUEST_N == !(KEY_DOWN_REQUEST || $past(KNOB_REQUEST)))
    else $error("service request not the combination");
  a_code_inverted: assert property (@(posedge CLK) disable iff (!RESET_N)
    hit_code |=> READ_DATA[2:0] == ~$past(col_enc[2:0]) && READ_VALID)
    else $error("column code not inverted on read");
  a_lowest_row: assert property (@(posedge CLK) disable iff (!RESET_N)
    !lock_q && !row_d_q[0] |-> row_enc[2:0] == CODE_IDLE)
    else $error("line 0 did not win");
  // Registered outputs must mirror the internal state they stage
  a_pressed_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    KEY_PRESSED_N == !$past(pressed))
    else $error("key-pressed output does not follow the encoders");
  a_lockout_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    LOCKOUT == lock_q)
    else $error("lockout output differs from latched bit");
  a_kdr_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    KEY_DOWN_REQUEST == req_q)
    else $error("key-down request output differs from state");
  // Read bus answers only in the cycle after a read hit
  a_read_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    !READ_VALID |-> READ_DATA == 8'h00)
    else $error("read data not zero outside an answer");
  a_valid_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
    READ_VALID == $past(hit_code))
    else $error("read answer not one cycle after the hit");
  a_row_code: assert property (@(posedge CLK) disable iff (!RESET_N)
    hit_code |=> READ_DATA[5:3] == ~$past(row_enc[2:0]))
    else $error("row code not inverted on read");
  a_flag_bit: assert property (@(posedge CLK) disable iff (!RESET_N)
    hit_code |=> READ_DATA[6] == !$past(req_q) && !READ_DATA[7])
    else $error("request flag bit wrong on read");
  // Lockout leaves both encoders reporting no active line
  a_lock_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
    lock_q |-> row_enc[3] && col_enc[3])
    else $error("encoder active while locked out");
  a_lowest_col: assert property (@(posedge CLK) disable iff (!RESET_N)
    !lock_q && !col_d_q[0] |-> col_enc[2:0] == CODE_IDLE)
    else $error("column line 0 did not win");
  // Timer loads the full interval on a fresh press
  a_timer_start: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_IDLE && pressed |=> st_q == ST_TIMING && cnt_q == CNT_W'(QUAL_CYCLES))
    else $error("timer did not load the interval");
  // A key still held at the end becomes a valid key-down
  a_valid_keydown: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_TIMING && cnt_q == CNT_ONE && pressed |=> req_q && st_q == ST_REQ)
    else $error("held key not registered");
  // Request stays up until the host acknowledges it
  a_req_holds: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_REQ && !HOST.ack |=> req_q)
    else $error("request dropped without acknowledge");
  // Main scenarios the bench is expected to reach
  c_ack: cover property (@(posedge CLK) disable iff (!RESET_N) st_q == ST_REQ && HOST.ack);
  c_valid_press: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(req_q));
  c_discard: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_q == ST_TIMING ##1 st_q == ST_IDLE);
  c_lockout: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(lock_q));
  c_read: cover property (@(posedge CLK) disable iff (!RESET_N) hit_code && req_q);
endmodule : kbe_keyboard_encoder

// *** sim/kbe_host_model.sv ***
// Host processor model: lockout writes, key code reads and acknowledge strobes
`timescale 1ns/1ps
module kbe_host_model (
  // Clock
  input wire logic clk,
  // Strobes toward the encoder
  output kbe_pkg::kbe_host_s host,
  output logic [7:0] data,
  // Answer from the encoder
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  import kbe_pkg::*;
  // ==========================================================
  // Idle bus at time zero
  initial begin
    host = '0;
    data = 8'h00;
  end
  // One-cycle strobe; the released data bus shows a changed value
  task automatic strobe(input logic w, r, a, input logic [1:0] rs, input logic [7:0] d);
    @(posedge clk);
    host <= '{wr: w, rd: r, ack: a, addr: IO_ADDR, regsel: rs};
    data <= d;
    @(posedge clk);
    host <= '0;
    data <= ~d;
    // Step past the answering edge so registered outputs have settled
    #1;
  endtask : strobe
  task automatic write_reg(input logic [1:0] rs, input logic [7:0] d);
    strobe(1'b1, 1'b0, 1'b0, rs, d);
  endtask : write_reg
  // key code read, answer one cycle later
  task automatic read_code(output logic [7:0] q, output logic v);
    strobe(1'b0, 1'b1, 1'b0, REG_CODE, 8'h00);
    q = read_data;
    v = read_valid;
  endtask : read_code
  task automatic ack();
    strobe(1'b0, 1'b0, 1'b1, 2'h0, 8'h00);
  endtask : ack
endmodule : kbe_host_model

// *** sim/kbe_keyboard_encoder_tb.sv ***
// Testbench for the keyboard encoder with key-down qualifier
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t value differs", $time); end end
module kbe_keyboard_encoder_tb;
  import kbe_pkg::*;
  // Shortened qualifying interval keeps the run short
  localparam int unsigned QUAL_TB = 400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] row_n = 8'hFF;
  logic [7:0] col_n = 8'hFF;
  logic knob = 1'b0;
  kbe_host_s host;
  logic [7:0] hdata, rdata;
  logic rvalid, kp_n, kdr, srq_n, lock;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  logic [7:0] q, r, c;
  logic v;
  always #12.5 clk = ~clk;
  kbe_keyboard_encoder #(.QUAL_CYCLES(QUAL_TB)) dut (.CLK(clk), .RESET_N(rst_n), .ROW_N(row_n),
    .COL_N(col_n),
    .HOST(host), .HOST_DATA(hdata), .KNOB_REQUEST(knob), .READ_DATA(rdata),
    .READ_VALID(rvalid), .KEY_PRESSED_N(kp_n), .KEY_DOWN_REQUEST(kdr),
    .SERVICE_REQUEST_N(srq_n), .LOCKOUT(lock));
  kbe_host_model hst (.clk(clk), .host(host), .data(hdata), .read_data(rdata),
    .read_valid(rvalid));
  // ==========================================================
  // Lowest active line wins; no line reads as zero
  function automatic logic [2:0] low_line(input logic [7:0] act);
    low_line = 3'h0;
    for (int i = 7; i >= 0; i--) if (act[i]) low_line = i[2:0];
  endfunction : low_line
  // Drive the matrix, let it settle, read and compare the code
  task automatic press_check(input logic [7:0] ra, ca, input logic en);
    @(posedge clk);
    row_n <= ~ra;
    col_n <= ~ca;
    repeat (8) @(posedge clk);
    hst.read_code(q, v);
    `CHK(v, 1'b1)
    `CHK(q, {1'b0, ~kdr, en ? low_line(ra) : 3'h0, en ? low_line(ca) : 3'h0})
    `CHK(kp_n, ~(en & (|ra)))
  endtask : press_check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Timeout guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40 * QUAL_TB) begin
      fail_count++;
      complete_run();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(85638));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({kdr, srq_n, lock, kp_n}, 4'h5)
    hst.write_reg(REG_LOCK, 8'h80);
    `CHK(lock, 1'b1)
    press_check(8'h21, 8'h80, 1'b0);
    hst.write_reg(2'h2, 8'h00);
    `CHK(lock, 1'b1)
    hst.write_reg(REG_LOCK, 8'h00);
    t0 = cyc;
    `CHK(lock, 1'b0)
    press_check(8'h01, 8'h80, 1'b1);
    for (int k = 0; k < 10; k++) begin
      r = 8'($urandom_range(1, 255));
      c = 8'($urandom_range(1, 255));
      press_check(r, c, 1'b1);
    end
    for (int k = 0; k < QUAL_TB + 100 && kdr !== 1'b1; k++) @(posedge clk);
    `CHK(kdr, 1'b1)
    `CHK(srq_n, 1'b0)
    `CHK((cyc - t0 >= QUAL_TB) && (cyc - t0 <= QUAL_TB + 30), 1'b1)
    press_check(8'h40, 8'h02, 1'b1);
    `CHK(q[6], 1'b0)
    press_check(8'h00, 8'h00, 1'b1);
    hst.ack();
    @(posedge clk);
    `CHK({kdr, srq_n}, 2'b01)
    press_check(8'h04, 8'h10, 1'b1);
    repeat (10) @(posedge clk);
    row_n <= 8'hFF;
    col_n <= 8'hFF;
    repeat (QUAL_TB + 100) @(posedge clk);
    `CHK({kdr, srq_n}, 2'b01)
    knob <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(srq_n, 1'b0)
    knob <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(srq_n, 1'b1)
    complete_run();
  end
endmodule : kbe_keyboard_encoder_tb
